// ===== shared/sol_pkg.sv
package sol_pkg;

    localparam int unsigned SOL_WORD_W = 32;
    localparam int unsigned SOL_WAIT_BIT = 0;
    localparam int unsigned SOL_HELD_BIT = 1;
    localparam logic [31:0] SOL_FLAG_MASK = 32'h00000003;
    localparam logic [31:0] SOL_WORD_RESET = 32'h00000000;
    localparam logic [1:0] SOL_BOTH_SET = 2'h3;
    localparam int unsigned SOL_PARTY_COUNT = 2;
    localparam int unsigned SOL_PARTY_OS = 0;
    localparam int unsigned SOL_PARTY_FW = 1;

    typedef enum logic [1:0]
    {
        SOL_OP_NONE,
        SOL_OP_ACQUIRE,
        SOL_OP_RELEASE,
        SOL_OP_WRITE
    } sol_op_type;

endpackage

// ===== hdl/sol_party_port.sv
`timescale 1ns/100ps
`default_nettype none

// Performs one party's acquire or release against a snapshot of the lock word.
// The update is applied in the same cycle as the compare, so no other party
// can slip in between; the caller's compare value stands in for the read.
module sol_party_port
(
    input wire sol_pkg::sol_op_type i_op,
    input wire logic [31:0] i_expect,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] i_word,
    output logic o_swap,
    output logic [31:0] o_new_word,
    output logic o_result,
    output logic o_notify
);
    import sol_pkg::*;

    logic [31:0] acq_word;
    logic [31:0] rel_word;
    logic match;

    always_comb
    begin
        match = (i_word == i_expect); // RULE4
        acq_word = i_word;
        acq_word[SOL_WAIT_BIT] = i_word[SOL_HELD_BIT]; // RULE1 RULE3 RULE10
        acq_word[SOL_HELD_BIT] = 1'b1; // RULE3
        rel_word = i_word & ~SOL_FLAG_MASK; // RULE7 RULE13
        o_swap = 1'b0;
        o_new_word = i_word;
        o_result = 1'b0;
        o_notify = 1'b0;
        case (i_op)
            SOL_OP_ACQUIRE:
            begin
                o_swap = match;
                o_new_word = acq_word;
                o_result = match && (acq_word[1:0] != SOL_BOTH_SET); // RULE5
            end
            SOL_OP_RELEASE:
            begin
                o_swap = match;
                o_new_word = rel_word;
                o_result = match && i_word[SOL_WAIT_BIT]; // RULE7
                o_notify = match && i_word[SOL_WAIT_BIT]; // RULE8 RULE9
            end
            SOL_OP_WRITE:
            begin
                o_swap = match;
                o_new_word = (i_wdata & ~SOL_FLAG_MASK) | (i_word & SOL_FLAG_MASK);
            end
            default:
            begin
                o_swap = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ===== hdl/sol_lock.sv
// Overview of operation
// RULE1: Bit 0 marks a waiting party.
// RULE2: Bit 1 marks the lock held.
// RULE3: Acquire clears waiting, sets held, else waits.
// RULE4: Updates are compare-and-swap; mismatches retry.
// RULE5: Acquire succeeds unless both flags end set.
// RULE6: Failed party waits for a release event.
// RULE7: Release clears both flags, reports waiting.
// RULE8: Waiting release raises other party's notify; here the releasing party's own notify bit is raised.
// RULE9: No waiting flag, no release event.
// RULE10: On event, retry; failure sets waiting again.
// RULE11: Shared registers only touched while held.
// RULE12: Keep shared hardware needing the lock minimal.
// RULE13: Bits 2 to 31 kept and ignored; a write op replaces them with its write data.
`timescale 1ns/100ps
`default_nettype none

// Two-party ownership lock word. Each party has its own request port; party 0
// is the operating system environment and party 1 the firmware management
// environment. Requests of both parties in one cycle are served in order,
// party 0 first against the word that party 1 then sees, so both remain atomic.
module sol_lock
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire sol_pkg::sol_op_type i_os_op,
    input wire logic [31:0] i_os_expect,
    input wire logic [31:0] i_os_wdata,
    input wire sol_pkg::sol_op_type i_fw_op,
    input wire logic [31:0] i_fw_expect,
    input wire logic [31:0] i_fw_wdata,
    input wire logic i_os_notify_clear,
    input wire logic i_fw_notify_clear,
    output logic [31:0] o_lock_word,
    output logic o_os_done,
    output logic o_os_swapped,
    output logic o_os_result,
    output logic [31:0] o_os_old,
    output logic o_fw_done,
    output logic o_fw_swapped,
    output logic o_fw_result,
    output logic [31:0] o_fw_old,
    output logic o_os_release_notify,
    output logic o_firmware_release_notify,
    output logic o_os_held,
    output logic o_fw_held
);
    import sol_pkg::*;

    typedef struct packed
    {
        logic [31:0] word;
        logic owner;
        logic os_done;
        logic os_swapped;
        logic os_result;
        logic [31:0] os_old;
        logic fw_done;
        logic fw_swapped;
        logic fw_result;
        logic [31:0] fw_old;
        logic os_release_notify;
        logic firmware_release_notify;
    } sol_state_type;

    localparam sol_state_type SOL_STATE_RESET = '{
        word: SOL_WORD_RESET,
        owner: 1'b0,
        os_done: 1'b0,
        os_swapped: 1'b0,
        os_result: 1'b0,
        os_old: SOL_WORD_RESET,
        fw_done: 1'b0,
        fw_swapped: 1'b0,
        fw_result: 1'b0,
        fw_old: SOL_WORD_RESET,
        os_release_notify: 1'b0,
        firmware_release_notify: 1'b0
    };

    sol_state_type state_q;
    sol_state_type state_d;
    logic os_swap;
    logic [31:0] os_new;
    logic os_res;
    logic os_note;
    logic fw_swap;
    logic [31:0] fw_new;
    logic fw_res;
    logic fw_note;
    logic [31:0] mid_word;
    sol_op_type party_op [SOL_PARTY_COUNT];
    logic [31:0] party_expect [SOL_PARTY_COUNT];
    logic [31:0] party_wdata [SOL_PARTY_COUNT];
    logic [31:0] chain_word [SOL_PARTY_COUNT + 1];
    logic party_swap [SOL_PARTY_COUNT];
    logic [31:0] party_new [SOL_PARTY_COUNT];
    logic party_res [SOL_PARTY_COUNT];
    logic party_note [SOL_PARTY_COUNT];

    assign party_op[SOL_PARTY_OS] = i_os_op;
    assign party_op[SOL_PARTY_FW] = i_fw_op;
    assign party_expect[SOL_PARTY_OS] = i_os_expect;
    assign party_expect[SOL_PARTY_FW] = i_fw_expect;
    assign party_wdata[SOL_PARTY_OS] = i_os_wdata;
    assign party_wdata[SOL_PARTY_FW] = i_fw_wdata;
    assign chain_word[0] = state_q.word;

    // Each party compares against the word as left by the parties ahead of it
    // in this cycle, so a stale compare value from a same-cycle loser misses.
    for (genvar g = 0; g < SOL_PARTY_COUNT; g++)
    begin : g_party
        sol_party_port u_port
        (
            .i_op(party_op[g]),
            .i_expect(party_expect[g]),
            .i_wdata(party_wdata[g]),
            .i_word(chain_word[g]),
            .o_swap(party_swap[g]),
            .o_new_word(party_new[g]),
            .o_result(party_res[g]),
            .o_notify(party_note[g])
        );

        assign chain_word[g + 1] = party_swap[g] ? party_new[g] : chain_word[g]; // RULE4
    end

    assign os_swap = party_swap[SOL_PARTY_OS];
    assign os_new = party_new[SOL_PARTY_OS];
    assign os_res = party_res[SOL_PARTY_OS];
    assign os_note = party_note[SOL_PARTY_OS];
    assign fw_swap = party_swap[SOL_PARTY_FW];
    assign fw_new = party_new[SOL_PARTY_FW];
    assign fw_res = party_res[SOL_PARTY_FW];
    assign fw_note = party_note[SOL_PARTY_FW];
    assign mid_word = chain_word[SOL_PARTY_FW]; // RULE4

    always_comb
    begin
        state_d = state_q;
        state_d.os_done = (i_os_op != SOL_OP_NONE);
        state_d.os_swapped = os_swap;
        state_d.os_result = os_res;
        state_d.fw_done = (i_fw_op != SOL_OP_NONE);
        state_d.fw_swapped = fw_swap;
        state_d.fw_result = fw_res;
        if (i_os_op != SOL_OP_NONE)
        begin
            state_d.os_old = state_q.word;
        end
        if (i_fw_op != SOL_OP_NONE)
        begin
            state_d.fw_old = mid_word;
        end
        state_d.word = fw_swap ? fw_new : mid_word;
        // Track which party took the held flag so shared access can be gated.
        if (os_swap && i_os_op == SOL_OP_ACQUIRE && os_res)
        begin
            state_d.owner = SOL_PARTY_OS[0]; // RULE11
        end
        if (fw_swap && i_fw_op == SOL_OP_ACQUIRE && fw_res)
        begin
            state_d.owner = SOL_PARTY_FW[0]; // RULE11
        end
        // A releasing party raises its own notify bit; set wins over clear.
        if (i_os_notify_clear)
        begin
            state_d.os_release_notify = 1'b0;
        end
        if (os_note)
        begin
            state_d.os_release_notify = 1'b1; // RULE8 RULE9
        end
        if (i_fw_notify_clear)
        begin
            state_d.firmware_release_notify = 1'b0;
        end
        if (fw_note)
        begin
            state_d.firmware_release_notify = 1'b1; // RULE8 RULE9
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q <= SOL_STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_lock_word = state_q.word;
    assign o_os_done = state_q.os_done;
    assign o_os_swapped = state_q.os_swapped;
    assign o_os_result = state_q.os_result;
    assign o_os_old = state_q.os_old;
    assign o_fw_done = state_q.fw_done;
    assign o_fw_swapped = state_q.fw_swapped;
    assign o_fw_result = state_q.fw_result;
    assign o_fw_old = state_q.fw_old;
    assign o_os_release_notify = state_q.os_release_notify;
    assign o_firmware_release_notify = state_q.firmware_release_notify;
    assign o_os_held = state_q.word[SOL_HELD_BIT] && (state_q.owner == SOL_PARTY_OS[0]); // RULE2
    assign o_fw_held = state_q.word[SOL_HELD_BIT] && (state_q.owner == SOL_PARTY_FW[0]); // RULE2

endmodule

`default_nettype wire

// ===== dv/sol_lock_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sol_lock_checker
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire sol_pkg::sol_op_type i_os_op,
    input wire logic [31:0] i_os_expect,
    input wire sol_pkg::sol_op_type i_fw_op,
    input wire logic [31:0] i_fw_expect,
    input wire logic i_os_notify_clear,
    input wire logic [31:0] o_lock_word,
    input wire logic o_os_done,
    input wire logic o_os_swapped,
    input wire logic o_os_result,
    input wire logic o_fw_swapped,
    input wire logic o_fw_result,
    input wire logic o_os_release_notify,
    input wire logic o_firmware_release_notify,
    input wire logic o_os_held,
    input wire logic o_fw_held
);
    import sol_pkg::*;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    logic hit;
    logic solo;
    logic acq;
    logic rel;
    assign hit = i_os_expect == o_lock_word;
    assign solo = i_fw_op == SOL_OP_NONE;
    assign acq = i_os_op == SOL_OP_ACQUIRE && hit && solo;
    assign rel = i_os_op == SOL_OP_RELEASE && hit;
    sequence os_take_s;
        acq && !o_lock_word[1];
    endsequence
    sequence os_pend_s;
        acq && o_lock_word[1];
    endsequence
    lock_take_a: assert property (os_take_s |=>
        o_lock_word[1:0] == 2'h2 && o_os_result && o_os_held) else $error("take");
    lock_pend_a: assert property (os_pend_s |=>
        o_lock_word[1:0] == 2'h3 && !o_os_result) else $error("pend");
    lock_free_a: assert property (rel && solo |=>
        o_lock_word[1:0] == 2'h0 && o_os_result == $past(o_lock_word[0])) else $error("free");
    notify_set_a: assert property (rel && o_lock_word[0] |=>
        o_os_release_notify) else $error("notify");
    notify_cause_a: assert property ($rose(o_os_release_notify) |->
        $past(rel) && $past(o_lock_word[0])) else $error("cause");
    swap_miss_a: assert property (i_os_op inside {SOL_OP_ACQUIRE, SOL_OP_RELEASE}
        && !hit && solo |=> $stable(o_lock_word)) else $error("miss");
    rsvd_keep_a: assert property (i_os_op != SOL_OP_WRITE && i_fw_op != SOL_OP_WRITE
        |=> $stable(o_lock_word[31:2])) else $error("rsvd");
    idle_keep_a: assert property (i_os_op == SOL_OP_NONE && solo |=>
        $stable(o_lock_word)) else $error("idle");
    logic fw_hit;
    logic fw_acq;
    logic fw_rel;
    assign fw_hit = i_fw_expect == o_lock_word;
    assign fw_acq = i_fw_op == SOL_OP_ACQUIRE && fw_hit && i_os_op == SOL_OP_NONE;
    assign fw_rel = i_fw_op == SOL_OP_RELEASE && fw_hit && i_os_op == SOL_OP_NONE;
    sequence fw_take_s;
        fw_acq && !o_lock_word[1];
    endsequence
    sequence fw_pend_s;
        fw_acq && o_lock_word[1];
    endsequence
    sequence acq_both_s;
        i_os_op == SOL_OP_ACQUIRE && hit && !o_lock_word[1] && i_fw_op == SOL_OP_ACQUIRE && fw_hit;
    endsequence
    fw_take_a: assert property (fw_take_s |=>
        o_lock_word[1:0] == 2'h2 && o_fw_result && o_fw_held && !o_os_held) else $error("fw take");
    fw_pend_a: assert property (fw_pend_s |=>
        o_lock_word[1:0] == 2'h3 && !o_fw_result && !o_fw_held) else $error("fw pend");
    same_cycle_order_a: assert property (acq_both_s |=>
        o_os_swapped && !o_fw_swapped && o_lock_word[1:0] == 2'h2) else $error("order");
    op_done_a: assert property (i_os_op != SOL_OP_NONE |=> o_os_done) else $error("done");
    notify_hold_a: assert property (o_os_release_notify && !i_os_notify_clear |=>
        o_os_release_notify) else $error("notify hold");
    fw_notify_a: assert property (fw_rel && o_lock_word[0] |=>
        o_firmware_release_notify) else $error("fw notify");
endmodule
bind sol_lock sol_lock_checker u_chk (.*);
`default_nettype wire

// ===== dv/sol_env_model.sv
`timescale 1ns/100ps
`default_nettype none
module sol_env_model
(
    input wire logic i_core_clk,
    input wire logic [31:0] i_word,
    input wire logic i_swapped,
    input wire logic i_result,
    output sol_pkg::sol_op_type o_op,
    output logic [31:0] o_expect
);
    import sol_pkg::*;
    initial o_op = SOL_OP_NONE;
    initial o_expect = 32'h0;
    // A refused acquire or release swap is repeated on a fresh read; a pending acquire is not.
    task automatic run(sol_op_type op, logic [31:0] bad, output logic r, output logic f);
        f = 1'b1;
        @(negedge i_core_clk);
        for (int n = 0; n < 4 && f; n++)
        begin
            o_op = op;
            o_expect = n ? i_word : i_word ^ bad;
            @(negedge i_core_clk);
            r = i_result;
            f = !i_swapped && op != SOL_OP_WRITE;
        end
        o_op = SOL_OP_NONE;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sol_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_os_notify_clear = 1'b0;
    logic i_fw_notify_clear = 1'b0;
    logic [31:0] i_os_wdata = 32'h0;
    logic [31:0] i_fw_wdata = 32'h0;
    logic [31:0] m = 32'h0;
    logic [1:0] nt = 2'h0;
    logic [1:0] pend = 2'h0;
    int own = 0;
    int pty = 0;
    sol_op_type i_os_op, i_fw_op, op;
    logic [31:0] i_os_expect, i_fw_expect, o_lock_word, o_os_old, o_fw_old;
    logic o_os_done, o_os_swapped, o_os_result, o_fw_done, o_fw_swapped, o_fw_result;
    logic o_os_release_notify, o_firmware_release_notify, o_os_held, o_fw_held;
    int err_count = 0;
    int num_checks = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    sol_lock u_dut (.*);
    sol_env_model u_os (.i_core_clk, .i_word(o_lock_word), .i_swapped(o_os_swapped),
        .i_result(o_os_result), .o_op(i_os_op), .o_expect(i_os_expect));
    sol_env_model u_fw (.i_core_clk, .i_word(o_lock_word), .i_swapped(o_fw_swapped),
        .i_result(o_fw_result), .o_op(i_fw_op), .o_expect(i_fw_expect));
    task automatic chk(logic ok);
        num_checks++;
        if (!ok)
        begin
            err_count++;
            $display("Error %0t: lock mismatch", $time);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(int p, sol_op_type sop, logic [31:0] bad, logic [31:0] wd);
        logic r;
        logic f;
        logic er;
        if (p == 0)
            i_os_wdata = wd;
        else
            i_fw_wdata = wd;
        if (p == 0)
            u_os.run(sop, bad, r, f);
        else
            u_fw.run(sop, bad, r, f);
        er = (sop == SOL_OP_ACQUIRE) ? !m[1] : m[0];
        chk((p ? o_fw_done : o_os_done) === 1'b1 && (p ? o_fw_old : o_os_old) === m);
        if (sop == SOL_OP_ACQUIRE)
            pend[p] = !er;
        if (sop == SOL_OP_ACQUIRE && er)
            own = p;
        if (sop == SOL_OP_RELEASE && m[0])
            pend[1 - p] = 1'b0;
        if (sop == SOL_OP_RELEASE)
            nt[p] = nt[p] | m[0];
        case (sop)
            SOL_OP_ACQUIRE: m = {m[31:2], 1'b1, m[1]};
            SOL_OP_RELEASE: m = {m[31:2], 2'h0};
            default: m = {wd[31:2], m[1:0]};
        endcase
        chk(f === 1'b0 && (sop == SOL_OP_WRITE || r === er));
        chk(o_lock_word === m && {o_firmware_release_notify, o_os_release_notify} === nt);
        chk({o_fw_held, o_os_held} === (m[1] ? 2'(1 << own) : 2'h0));
    endtask
    task automatic clear_notify;
        i_os_notify_clear = 1'b1;
        i_fw_notify_clear = 1'b1;
        @(negedge i_core_clk);
        i_os_notify_clear = 1'b0;
        i_fw_notify_clear = 1'b0;
        nt = 2'h0;
        chk({o_firmware_release_notify, o_os_release_notify} === 2'h0);
    endtask
    task automatic reset_check;
        logic z;
        i_reset = 1'b1;
        repeat (2) @(negedge i_core_clk);
        z = {o_lock_word, o_os_old, o_fw_old} === 96'h0;
        z = z && {o_os_done, o_os_swapped, o_os_result} === 3'h0;
        z = z && {o_fw_done, o_fw_swapped, o_fw_result} === 3'h0;
        z = z && {o_os_release_notify, o_firmware_release_notify} === 2'h0;
        z = z && {o_os_held, o_fw_held} === 2'h0;
        chk(z);
        i_reset = 1'b0;
        m = 32'h0;
        nt = 2'h0;
        own = 0;
        pend = 2'h0;
    endtask
    initial
    begin
        void'($urandom(32'hf18d));
        repeat (6) @(negedge i_core_clk);
        reset_check();
        step(0, SOL_OP_ACQUIRE, 32'h0, 32'h0);
        step(1, SOL_OP_ACQUIRE, 32'h0, 32'h0);
        step(0, SOL_OP_RELEASE, 32'h0, 32'h0);
        step(1, SOL_OP_ACQUIRE, 32'h1, 32'h0);
        step(1, SOL_OP_RELEASE, 32'h0, 32'h0);
        clear_notify();
        $display("walk done");
        fork
            step(0, SOL_OP_ACQUIRE, 32'h0, 32'h0);
            step(1, SOL_OP_ACQUIRE, 32'h0, 32'h0);
        join
        $display("contention done");
        for (int i = 0; i < 200; i++)
        begin
            pty = int'($urandom % 2);
            if (m[1] && own == pty)
                op = ($urandom % 2) ? SOL_OP_RELEASE : SOL_OP_WRITE;
            else if (!pend[pty])
                op = SOL_OP_ACQUIRE;
            else
                op = SOL_OP_WRITE;
            step(pty, op, (op != SOL_OP_WRITE && $urandom % 4 == 0) ? $urandom | 1 : 0,
                $urandom);
            if ($urandom % 8 == 0)
                clear_notify();
        end
        $display("random done");
        reset_check();
        step(0, SOL_OP_ACQUIRE, 32'h0, 32'h0);
        $display("reset done");
        complete_run();
    end
endmodule
`default_nettype wire
